// ### rtl/ies_sev_select.sv
// Severity select register with AHB-Lite slave; routes error events to AER classes.
// Assumes err_i pulses come from logic on sys_clk_i; one slave on the bus.
// Notes on behaviour
// - Severity zero correctable, one uncorrectable
// - Bits 17,16 replay control; reset one, zero
// - Bit 15 datapath parity, resets to one
// - Bits 14..11 egress buffer errors severity
// - Bits 10..7 ingress buffer errors severity
// - Bits 6..4 egress timeouts; reset 0,0,1
// - Bits 2..0 ingress timeouts; reset 0,0,1
// - Masked sources never forwarded to reporting
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module ies_sev_select (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 clk_en_i,
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic [31:0]               hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	input  wire logic [17:0]          err_i,
	output ies_pkg::ies_report_s      report_o,
	output logic [31:0]               severity_o
);

	// ****************************************
	// Address decode
	// ****************************************
	// Only the low twelve address bits are decoded, so the map aliases every 4 KB.
	function automatic logic reg_hit(
		input logic [11:0] addr,
		input logic [11:0] offset
	);
		return addr == offset;
	endfunction : reg_hit

	// ****************************************
	// Bus address phase capture
	// ****************************************
	logic        wr_pend_r;
	logic [11:0] wr_addr_r;
	logic [31:0] sev_r;
	logic [31:0] mask_r;
	logic [31:0] rdata_r;
	ies_pkg::ies_report_s rep_r;

	wire         addr_ok  = hsel_i && hready_i && htrans_i[1];
	wire         rd_take  = addr_ok && !hwrite_i;
	wire         wr_take  = addr_ok && hwrite_i;
	wire         sev_hit  = wr_pend_r && reg_hit(wr_addr_r, ies_pkg::SEV_OFFSET);
	wire         mask_hit = wr_pend_r && reg_hit(wr_addr_r, ies_pkg::MASK_OFFSET);
	wire [31:0]  sev_nxt  = hwdata_i & ies_pkg::SEV_WMASK;
	wire [31:0]  mask_nxt = hwdata_i & ies_pkg::SEV_WMASK;
	// A read right behind a write to the same register must see the new value,
	// since the write only lands at the end of its data phase.
	wire [31:0]  sev_rd   = sev_hit ? sev_nxt : sev_r;
	wire [31:0]  mask_rd  = mask_hit ? mask_nxt : mask_r;
	wire         rd_sev   = reg_hit(haddr_i[11:0], ies_pkg::SEV_OFFSET);
	wire         rd_mask  = reg_hit(haddr_i[11:0], ies_pkg::MASK_OFFSET);
	wire [31:0]  rd_sel   = rd_sev ? sev_rd : (rd_mask ? mask_rd : 32'h0000_0000);

	// Unmapped reads return zero and unmapped writes are dropped; always OKAY.
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = rdata_r;
	assign severity_o  = sev_r;
	assign report_o    = rep_r;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
			rdata_r   <= 32'h0000_0000;
		end else if (clk_en_i) begin
			wr_pend_r <= wr_take;
			wr_addr_r <= haddr_i[11:0];
			if (rd_take) begin
				rdata_r <= rd_sel;
			end
		end
	end

	// ****************************************
	// Severity and mask registers
	// ****************************************
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sev_r  <= ies_pkg::SEV_RESET;
			mask_r <= ies_pkg::MASK_RESET;
		end else if (clk_en_i) begin
			if (sev_hit) begin
				sev_r <= sev_nxt;
			end
			if (mask_hit) begin
				mask_r <= mask_nxt;
			end
		end
	end

	// ****************************************
	// Error routing
	// ****************************************
	// Registered so the report lines are glitch free toward the AER logic.
	wire [17:0] fwd = err_i & ~mask_r[17:0] & ies_pkg::SEV_WMASK[17:0];

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rep_r <= '0;
		end else if (clk_en_i) begin
			rep_r.uncorr <= fwd & sev_r[17:0];
			rep_r.corr   <= fwd & ~sev_r[17:0];
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	a_sev_reset: assert property (@(posedge sys_clk_i)
		rst_i |=> sev_r == 32'h0002_d511)
		else $error("severity reset value wrong");
	a_rst_replay: assert property (@(posedge sys_clk_i)
		rst_i |=> sev_r[17:16] == 2'h2)
		else $error("replay severity reset wrong");
	a_rst_parity: assert property (@(posedge sys_clk_i)
		rst_i |=> sev_r[15] == 1'h1)
		else $error("parity severity reset wrong");
	a_rst_egress: assert property (@(posedge sys_clk_i)
		rst_i |=> sev_r[14:11] == 4'ha)
		else $error("egress severity reset wrong");
	a_rst_ingress: assert property (@(posedge sys_clk_i)
		rst_i |=> sev_r[10:7] == 4'ha)
		else $error("ingress severity reset wrong");
	a_rst_eto: assert property (@(posedge sys_clk_i)
		rst_i |=> sev_r[6:4] == 3'h1)
		else $error("egress timeout reset wrong");
	a_rst_ito: assert property (@(posedge sys_clk_i)
		rst_i |=> sev_r[2:0] == 3'h1)
		else $error("ingress timeout reset wrong");
	a_out_reset: assert property (@(posedge sys_clk_i)
		rst_i |=> hrdata_o == 32'h0000_0000 && rep_r.corr == 18'h0_0000
			&& rep_r.uncorr == 18'h0_0000)
		else $error("outputs not cleared by reset");
	a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(sev_r[31:18] == 14'h0000) && !sev_r[3])
		else $error("reserved severity bit set");
	a_mask_rsvd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(mask_r[31:18] == 14'h0000) && !mask_r[3])
		else $error("reserved mask bit set");
	a_uncorr_route: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && err_i[15] && !mask_r[15] && sev_r[15] |=> rep_r.uncorr[15])
		else $error("uncorrectable not reported");
	a_corr_route: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && err_i[0] && !mask_r[0] && !sev_r[0] |=> rep_r.corr[0])
		else $error("correctable not reported");
	a_mask_block: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && mask_r[8] |=> !rep_r.corr[8] && !rep_r.uncorr[8])
		else $error("masked source forwarded");
	a_idle_quiet: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && err_i == 18'h0_0000 |=> rep_r.corr == 18'h0_0000
			&& rep_r.uncorr == 18'h0_0000)
		else $error("report without error");
	a_write_takes: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && sev_hit |=> sev_r == ($past(hwdata_i) & ies_pkg::SEV_WMASK))
		else $error("severity write lost");
	a_mask_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && mask_hit |=> mask_r == ($past(hwdata_i) & ies_pkg::SEV_WMASK))
		else $error("mask write lost");
	a_read_data: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && rd_take && rd_sev && !sev_hit |=> hrdata_o == $past(sev_r))
		else $error("severity read wrong");
	a_hold_sev: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!sev_hit |=> $stable(sev_r))
		else $error("severity changed without write");
	a_freeze_all: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!clk_en_i |=> $stable(sev_r) && $stable(mask_r) && $stable(rep_r)
			&& $stable(hrdata_o))
		else $error("state moved while frozen");
	a_no_both: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rep_r.corr & rep_r.uncorr) == 18'h0_0000)
		else $error("error in both classes");
	a_rsvd_route: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!rep_r.corr[3] && !rep_r.uncorr[3])
		else $error("reserved source reported");
	c_sev_write: cover property (@(posedge sys_clk_i) sev_hit && clk_en_i);
	c_read_sev: cover property (@(posedge sys_clk_i) rd_take && haddr_i[11:0] == 12'h048c);
	c_uncorr: cover property (@(posedge sys_clk_i) rep_r.uncorr != 18'h0_0000);
	c_corr: cover property (@(posedge sys_clk_i) rep_r.corr != 18'h0_0000);
	c_masked: cover property (@(posedge sys_clk_i) clk_en_i && err_i[8] && mask_r[8]);

endmodule : ies_sev_select

`default_nettype wire

// ### rtl/ies_pkg.sv
// Package for the internal error severity select block: map, fields, reset values.
// Assumes a single 32-bit AHB-Lite slave port on the core clock.
package ies_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] SEV_OFFSET   = 12'h048c;
	localparam logic [11:0] MASK_OFFSET  = 12'h0490;
	localparam logic [31:0] SEV_RESET    = 32'h0002_d511;
	localparam logic [31:0] SEV_WMASK    = 32'h0003_fff7;
	localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
	localparam int          NUM_SRC      = 18;

	// ****************************************
	// Bus encodings
	// ****************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	typedef struct packed {
		logic [NUM_SRC-1:0] corr;
		logic [NUM_SRC-1:0] uncorr;
	} ies_report_s;

endpackage : ies_pkg

// ### verif/ies_sev_select_tb.sv
// Bench for the severity select block: bus access, reset values, error routing.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module ies_sev_select_tb;
	logic sys_clk_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, clk_en_i = 1;
	logic [1:0] htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, severity_o, rd;
	logic [17:0] err_i = 18'h0;
	logic hreadyout_o, hresp_o;
	ies_pkg::ies_report_s report_o;
	int bad_count = 0, n_checks = 0;
	localparam logic [31:0] MASK_A = 32'h0000_0490;
	initial forever #2.5 sys_clk_i = ~sys_clk_i;
	ies_sev_select u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .err_i(err_i),
		.report_o(report_o), .severity_o(severity_o));
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Bounded wait for hready; a stuck bus ends the run
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge sys_clk_i);
		while (hreadyout_o !== 1'b1) begin
			n++;
			if (n > 50) begin
				bad_count++;
				complete_run();
			end
			@(posedge sys_clk_i);
		end
	endtask : wait_rdy
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= ies_pkg::HTRANS_NONSEQ;
		hwrite_i <= w;
		haddr_i <= a;
		wait_rdy();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_rdy();
		rd = hrdata_o;
	endtask : bus
	// All sources fire for one cycle; each unmasked source except reserved bit 3 lands in exactly one class
	task automatic route(input logic [31:0] s, input logic [31:0] m);
		err_i <= 18'h3_ffff;
		@(posedge sys_clk_i);
		err_i <= 18'h0_0000;
		#1 check(report_o, {~s[17:0] & ~m[17:0] & 18'h3_fff7, s[17:0] & ~m[17:0] & 18'h3_fff7});
		@(posedge sys_clk_i);
	endtask : route
	task automatic reset_vals;
		bus(1'b0, 32'(ies_pkg::SEV_OFFSET), 32'h0);
		check(36'(rd), 36'h0_0002_d511);
		check(36'(hresp_o), 36'h0);
		check(36'(severity_o), 36'h0_0002_d511);
		route(32'h0002_d511, 32'h0);
	endtask : reset_vals
	task automatic write_all;
		bus(1'b1, 32'(ies_pkg::SEV_OFFSET), 32'hffff_ffff);
		bus(1'b0, 32'(ies_pkg::SEV_OFFSET), 32'h0);
		check(36'(rd), 36'h0_0003_fff7);
		route(32'h0003_fff7, 32'h0);
		bus(1'b1, 32'(ies_pkg::SEV_OFFSET), 32'h0);
		bus(1'b1, 32'h0000_0500, 32'hffff_ffff);
		bus(1'b0, 32'h0000_0500, 32'h0);
		check(36'(rd), 36'h0);
		check(36'(severity_o), 36'h0);
		route(32'h0, 32'h0);
		bus(1'b1, MASK_A, 32'h0001_5555);
		route(32'h0, 32'h0001_5555);
	endtask : write_all
	// Clock enable low: a write and an error burst must leave no trace
	task automatic freeze;
		clk_en_i <= 1'b0;
		bus(1'b1, 32'(ies_pkg::SEV_OFFSET), 32'hffff_ffff);
		err_i <= 18'h3_ffff;
		@(posedge sys_clk_i);
		err_i <= 18'h0_0000;
		#1 check(report_o, 36'h0);
		check(36'(severity_o), 36'h0);
		@(posedge sys_clk_i);
		clk_en_i <= 1'b1;
		bus(1'b0, 32'(ies_pkg::SEV_OFFSET), 32'h0);
		check(36'(rd), 36'h0);
	endtask : freeze
	// Reset in mid run brings back the documented values
	task automatic mid_reset;
		bus(1'b1, 32'(ies_pkg::SEV_OFFSET), 32'h0);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		check(36'(severity_o), 36'h0_0002_d511);
		bus(1'b0, MASK_A, 32'h0);
		check(36'(rd), 36'h0);
		route(32'h0002_d511, 32'h0);
	endtask : mid_reset
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		reset_vals();
		write_all();
		freeze();
		mid_reset();
		complete_run();
	end
endmodule : ies_sev_select_tb
`default_nettype wire
